//--- irl_pkg.sv
package irl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the Avalon slave)
  localparam int unsigned REG_AW = 5;
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_STB    = 5'h08;
  localparam logic [4:0] OFF_SRE    = 5'h0c;
  localparam logic [4:0] OFF_EVENT  = 5'h10;

  // Control register fields
  localparam int unsigned CTRL_ADDR_LSB = 0;
  localparam int unsigned CTRL_ADDR_W   = 5;
  localparam int unsigned CTRL_TRIG_BIT = 8;
  localparam int unsigned CTRL_PRE_BIT  = 9;
  localparam logic [4:0]  CTRL_ADDR_RST = 5'h10;
  localparam logic        CTRL_TRIG_RST = 1'b0;
  localparam logic        CTRL_PRE_RST  = 1'b0;

  // Status register fields
  localparam int unsigned ST_HOST = 0;
  localparam int unsigned ST_LLO  = 1;
  localparam int unsigned ST_TACS = 2;
  localparam int unsigned ST_LACS = 3;
  localparam int unsigned ST_SPMS = 4;
  localparam int unsigned ST_SRQ  = 5;
  localparam int unsigned ST_REN  = 6;
  localparam int unsigned ST_W    = 7;

  // Event register fields, write one to clear
  localparam int unsigned EV_DCL = 0;
  localparam int unsigned EV_GET = 1;
  localparam int unsigned EV_IFC = 2;
  localparam int unsigned EV_W   = 3;

  // Status byte
  localparam int unsigned STB_RQS_BIT = 6;
  localparam logic [7:0]  STB_RST     = 8'h00;
  localparam logic [7:0]  SRE_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus command bytes, parity bit stripped
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins active low as on the cable, except the active-high output enables
  typedef struct packed {
    logic       atn_n;
    logic       ifc_n;
    logic       ren_n;
    logic       dav_n;
    logic       nrfd_n;
    logic       ndac_n;
    logic [7:0] dio_n;
  } irl_pin_in_t;

  typedef struct packed {
    logic [7:0] dio_n;
    logic       dio_oe;
    logic       dav_n;
    logic       dav_oe;
    logic       nrfd_n;
    logic       nrfd_oe;
    logic       ndac_n;
    logic       ndac_oe;
    logic       srq_n;
    logic       srq_oe;
  } irl_pin_out_t;

  typedef struct packed {
    logic host_control_lamp;
    logic talk_lamp;
    logic listener_lamp;
    logic srq_lamp;
  } irl_lamps_t;

  typedef enum logic [0:0] {
    AH_READY  = 1'b0,
    AH_ACCEPT = 1'b1
  } irl_ah_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_WAIT = 2'b01,
    SH_DAV  = 2'b10,
    SH_DONE = 2'b11
  } irl_sh_t;

endpackage

//--- irl_bus_ctrl.sv
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module irl_bus_ctrl #(
  parameter int unsigned KEYS = 8
) (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic [4:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire irl_pkg::irl_pin_in_t    pins_in,
  output irl_pkg::irl_pin_out_t        pins_out,
  input  wire logic                    key_local,
  input  wire logic [KEYS-1:0]         key_in,
  output logic [KEYS-1:0]              key_out,
  output irl_pkg::irl_lamps_t          lamps,
  output logic                         display_restore,
  output logic                         dev_clear,
  output logic                         bus_trigger,
  output logic                         pre_trigger,
  output logic [7:0]                   rx_data,
  output logic                         rx_valid
);
  import irl_pkg::*;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  function automatic logic [7:0] be_byte(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic       en);
    return en ? nw : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  irl_pin_in_t           pin_s1_q;
  irl_pin_in_t           pin_s2_q;
  logic [KEYS:0]         key_s1_q;
  logic [KEYS:0]         key_s2_q;
  logic                  local_prev_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      key_s1_q <= '0;
      key_s2_q <= '0;
      local_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= pins_in;
      pin_s2_q <= pin_s1_q;
      key_s1_q <= {key_local, key_in};
      key_s2_q <= key_s1_q;
      local_prev_q <= key_s2_q[KEYS];
    end
  end

  logic       atn;
  logic       ifc;
  logic       ren;
  logic       dav;
  logic       rdy_seen;
  logic       acc_seen;
  logic [7:0] dio;
  logic       local_press;

  assign atn      = ~pin_s2_q.atn_n;
  assign ifc      = ~pin_s2_q.ifc_n;
  assign ren      = ~pin_s2_q.ren_n;
  assign dav      = ~pin_s2_q.dav_n;
  assign rdy_seen = pin_s2_q.nrfd_n;
  assign acc_seen = pin_s2_q.ndac_n;
  assign dio      = ~pin_s2_q.dio_n;
  assign local_press = key_s2_q[KEYS] & ~local_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // State declarations
  logic [CTRL_ADDR_W-1:0] my_addr_q;
  logic                   trig_bus_q;
  logic                   pre_en_q;
  logic [7:0]             stb_q;
  logic [7:0]             sre_q;
  logic [EV_W-1:0]        event_q;
  logic                   remote_q;
  logic                   llo_q;
  logic                   tacs_q;
  logic                   lacs_q;
  logic                   spms_q;
  logic                   srq_q;
  logic                   rsv_prev_q;
  irl_ah_t                ah_q;
  irl_sh_t                sh_q;
  logic [7:0]             acc_byte_q;
  logic                   acc_cmd_q;
  logic                   acc_data_q;
  logic [7:0]             poll_byte_q;
  logic                   poll_done;
  logic                   ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptor handshake: takes commands under ATN, data while listening
  logic ah_part;
  assign ah_part = atn | lacs_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ah_q <= AH_READY;
      acc_byte_q <= 8'h00;
      acc_cmd_q <= 1'b0;
      acc_data_q <= 1'b0;
    end else begin
      acc_cmd_q <= 1'b0;
      acc_data_q <= 1'b0;
      unique case (ah_q)
        AH_READY: begin
          if (dav && ah_part && !ifc) begin
            ah_q <= AH_ACCEPT;
            acc_byte_q <= dio;
            acc_cmd_q <= atn;
            acc_data_q <= ~atn;
          end
        end
        AH_ACCEPT: begin
          if (!dav) begin
            ah_q <= AH_READY;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode, one cycle after the byte is taken
  logic [6:0] cb;
  logic       c_mla;
  logic       c_mta;
  logic       c_ota;
  logic       c_unl;
  logic       c_unt;
  logic       c_gtl;
  logic       c_sdc;
  logic       c_get;
  logic       c_llo;
  logic       c_dcl;
  logic       c_spe;
  logic       c_spd;

  assign cb    = acc_byte_q[6:0];
  assign c_mla = acc_cmd_q && cb == {GRP_LISTEN, my_addr_q};
  assign c_mta = acc_cmd_q && cb == {GRP_TALK, my_addr_q};
  assign c_unl = acc_cmd_q && cb == CMD_UNL;
  assign c_unt = acc_cmd_q && cb == CMD_UNT;
  assign c_ota = acc_cmd_q && cb[6:5] == GRP_TALK && !c_mta && !c_unt;
  assign c_gtl = acc_cmd_q && cb == CMD_GTL && lacs_q;
  assign c_sdc = acc_cmd_q && cb == CMD_SDC && lacs_q;
  assign c_get = acc_cmd_q && cb == CMD_GET && lacs_q;
  assign c_llo = acc_cmd_q && cb == CMD_LLO;
  assign c_dcl = acc_cmd_q && cb == CMD_DCL;
  assign c_spe = acc_cmd_q && cb == CMD_SPE;
  assign c_spd = acc_cmd_q && cb == CMD_SPD;

  ////////////////////////////////////////////////////////////////////////////
  // Talker and listener addressing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tacs_q <= 1'b0;
    end else if (ifc) begin
      tacs_q <= 1'b0;
    end else if (c_mta) begin
      tacs_q <= 1'b1;
    end else if (c_unt || c_ota || c_mla) begin
      tacs_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lacs_q <= 1'b0;
    end else if (ifc) begin
      lacs_q <= 1'b0;
    end else if (c_mla) begin
      lacs_q <= 1'b1;
    end else if (c_unl || c_mta) begin
      lacs_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote, local and lockout
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      remote_q <= 1'b0;
    end else if (!ren) begin
      remote_q <= 1'b0;
    end else if (ifc) begin
      remote_q <= 1'b0;
    end else if (c_mla) begin
      remote_q <= 1'b1;
    end else if (c_gtl) begin
      remote_q <= 1'b0;
    end else if (local_press && !llo_q) begin
      remote_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      llo_q <= 1'b0;
    end else if (!ren) begin
      llo_q <= 1'b0;
    end else if (c_llo) begin
      llo_q <= 1'b1;
    end else if (c_gtl) begin
      llo_q <= 1'b0;
    end
  end

  // Keys sampled through flops so a lock takes effect cleanly
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      key_out <= '0;
      display_restore <= 1'b0;
    end else begin
      key_out <= (remote_q || llo_q) ? '0 : key_s2_q[KEYS-1:0];
      display_restore <= local_press && !llo_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear, trigger and incoming data; of the registers, only the event register records clear and trigger
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dev_clear <= 1'b0;
      bus_trigger <= 1'b0;
      pre_trigger <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      dev_clear <= c_dcl || c_sdc;
      bus_trigger <= c_get && trig_bus_q;
      pre_trigger <= c_get && pre_en_q;
      rx_valid <= acc_data_q;
      if (acc_data_q) begin
        rx_data <= acc_byte_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service request and serial poll
  logic [7:0] summary;
  logic       rsv;

  // Software drives the summary bits; bit six is owned here
  assign summary = stb_q & ~(8'h01 << STB_RQS_BIT);
  assign rsv     = |(summary & sre_q);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsv_prev_q <= 1'b0;
      srq_q <= 1'b0;
    end else begin
      rsv_prev_q <= rsv;
      if (rsv && !rsv_prev_q) begin
        srq_q <= 1'b1;
      end else if (poll_done || !rsv) begin
        srq_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      spms_q <= 1'b0;
    end else if (ifc || c_spd) begin
      spms_q <= 1'b0;
    end else if (c_spe) begin
      spms_q <= 1'b1;
    end
  end

  // Source handshake; only the poll byte is sourced by this block
  logic sh_go;
  assign sh_go     = tacs_q && spms_q && !atn && !ifc;
  assign poll_done = sh_q == SH_DAV && acc_seen;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= SH_IDLE;
      poll_byte_q <= 8'h00;
    end else begin
      unique case (sh_q)
        SH_IDLE: begin
          if (sh_go) begin
            sh_q <= SH_WAIT;
            poll_byte_q <= summary | (8'(srq_q) << STB_RQS_BIT);
          end
        end
        SH_WAIT: begin
          if (!sh_go) begin
            sh_q <= SH_IDLE;
          end else if (rdy_seen) begin
            sh_q <= SH_DAV;
          end
        end
        SH_DAV: begin
          if (!sh_go) begin
            sh_q <= SH_IDLE;
          end else if (acc_seen) begin
            sh_q <= SH_DONE;
          end
        end
        SH_DONE: begin
          if (!sh_go) begin
            sh_q <= SH_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and lamps
  always_comb begin
    pins_out = '0;
    pins_out.dio_n   = ~poll_byte_q;
    pins_out.dio_oe  = sh_q == SH_WAIT || sh_q == SH_DAV;
    pins_out.dav_oe  = sh_q == SH_DAV;
    pins_out.nrfd_oe = ah_part && ah_q == AH_ACCEPT;
    pins_out.ndac_oe = ah_part && ah_q == AH_READY;
    pins_out.srq_oe  = srq_q;
  end

  assign lamps.host_control_lamp = remote_q;
  assign lamps.talk_lamp         = tacs_q;
  assign lamps.listener_lamp     = lacs_q;
  assign lamps.srq_lamp          = srq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer
  logic req;
  logic wr_ok;
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_ok           = avs_write && ack_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= 32'h0000_0000;
      if (hit(avs_address, OFF_CTRL)) begin
        avs_readdata[CTRL_ADDR_LSB +: CTRL_ADDR_W] <= my_addr_q;
        avs_readdata[CTRL_TRIG_BIT] <= trig_bus_q;
        avs_readdata[CTRL_PRE_BIT] <= pre_en_q;
      end else if (hit(avs_address, OFF_STATUS)) begin
        avs_readdata[ST_HOST] <= remote_q;
        avs_readdata[ST_LLO] <= llo_q;
        avs_readdata[ST_TACS] <= tacs_q;
        avs_readdata[ST_LACS] <= lacs_q;
        avs_readdata[ST_SPMS] <= spms_q;
        avs_readdata[ST_SRQ] <= srq_q;
        avs_readdata[ST_REN] <= ren;
      end else if (hit(avs_address, OFF_STB)) begin
        avs_readdata[7:0] <= summary | (8'(srq_q) << STB_RQS_BIT);
      end else if (hit(avs_address, OFF_SRE)) begin
        avs_readdata[7:0] <= sre_q;
      end else if (hit(avs_address, OFF_EVENT)) begin
        avs_readdata[EV_W-1:0] <= event_q;
      end
    end
  end

  // Bus events never reach these registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      my_addr_q <= CTRL_ADDR_RST;
      trig_bus_q <= CTRL_TRIG_RST;
      pre_en_q <= CTRL_PRE_RST;
      stb_q <= STB_RST;
      sre_q <= SRE_RST;
    end else if (wr_ok) begin
      if (hit(avs_address, OFF_CTRL)) begin
        if (avs_byteenable[0]) begin
          my_addr_q <= avs_writedata[CTRL_ADDR_LSB +: CTRL_ADDR_W];
        end
        if (avs_byteenable[1]) begin
          trig_bus_q <= avs_writedata[CTRL_TRIG_BIT];
          pre_en_q <= avs_writedata[CTRL_PRE_BIT];
        end
      end
      if (hit(avs_address, OFF_STB)) begin
        stb_q <= be_byte(stb_q, avs_writedata[7:0], avs_byteenable[0]);
      end
      if (hit(avs_address, OFF_SRE)) begin
        sre_q <= be_byte(sre_q, avs_writedata[7:0], avs_byteenable[0]);
      end
    end
  end

  // Sticky bus events; a new event wins over a clear in the same cycle
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  assign ev_set = {ifc, c_get, c_dcl || c_sdc};
  assign ev_clr = (wr_ok && hit(avs_address, OFF_EVENT) && avs_byteenable[0])
                  ? avs_writedata[EV_W-1:0] : '0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_q <= '0;
    end else begin
      event_q <= (event_q & ~ev_clr) | ev_set;
    end
  end

endmodule // irl_bus_ctrl

//--- irl_bus_ctrl_sva.sv
`timescale 1ns/1ps
module irl_bus_ctrl_sva #(
  parameter int unsigned KEYS = 8
) (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire irl_pkg::irl_pin_in_t  pins_in,
  input wire irl_pkg::irl_pin_out_t pins_out,
  input wire logic [KEYS-1:0]       key_out,
  input wire irl_pkg::irl_lamps_t   lamps,
  input wire logic                  display_restore,
  input wire logic                  dev_clear,
  input wire logic                  bus_trigger
);
  import irl_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Two sync flops plus one state edge must have passed
  sequence s_ifc_held;
    !pins_in.ifc_n [*5];
  endsequence

  sequence s_remote_kept;
    lamps.host_control_lamp [*2];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // REN is judged as the design saw it, three cycles earlier: two sync flops and the state flop
  AST_REMOTE_ON_LISTEN: assert property (
    $rose(lamps.host_control_lamp) |->
      lamps.listener_lamp && !$past(pins_in.ren_n, 3))
    else $error("remote entered without listen address and REN");
  AST_KEYS_LOCKED: assert property (
    s_remote_kept |-> key_out == '0)
    else $error("front panel key passed while remote");
  AST_IFC_IDLE: assert property (
    s_ifc_held |-> !lamps.talk_lamp && !lamps.listener_lamp &&
      !lamps.host_control_lamp)
    else $error("interface clear left a state active");
  AST_DCL_PULSE: assert property (
    dev_clear |=> !dev_clear)
    else $error("clear pulse longer than one cycle");
  AST_TRIG_LISTENER: assert property (
    bus_trigger |-> lamps.listener_lamp)
    else $error("trigger while not addressed");
  AST_TALK_XOR_LISTEN: assert property (
    !(lamps.talk_lamp && lamps.listener_lamp))
    else $error("talker and listener active together");
  AST_POLL_DRIVES: assert property (
    pins_out.dav_oe |-> pins_out.dio_oe)
    else $error("data valid without poll byte on the lines");
  // Byte is latched as the lines are taken; request may drop later
  AST_POLL_RQS: assert property (
    $rose(pins_out.dio_oe) |->
      pins_out.dio_n[STB_RQS_BIT] == !$past(lamps.srq_lamp))
    else $error("poll byte bit six differs from request");
  AST_LOCAL_DROPS: assert property (
    display_restore |-> ##2 !lamps.host_control_lamp)
    else $error("local key left remote set");
endmodule // irl_bus_ctrl_sva

bind irl_bus_ctrl irl_bus_ctrl_sva #(.KEYS(KEYS)) u_irl_bus_ctrl_sva (
  .mclk, .resetn, .pins_in, .pins_out, .key_out, .lamps,
  .display_restore, .dev_clear, .bus_trigger
);

//--- irl_ctl_model.sv
`timescale 1ns/1ps
module irl_ctl_model (
  input wire irl_pkg::irl_pin_out_t dev,
  input wire logic                  mclk,
  output irl_pkg::irl_pin_in_t      pins
);
  import irl_pkg::*;

  localparam int IFC_CYC = 12500;
  logic       atn_n  = 1'b1;
  logic       ifc_n  = 1'b1;
  logic       ren_n  = 1'b1;
  logic       dav_n  = 1'b1;
  logic       ndac_n = 1'b1;
  logic [7:0] dio_n  = 8'hff;
  int         slow   = 0;
  int         w;

  // Open-collector lines: pulled up, low if anyone drives
  assign pins = '{atn_n, ifc_n, ren_n, dav_n & ~dev.dav_oe,
                  ~dev.nrfd_oe, ndac_n & ~dev.ndac_oe,
                  dio_n & (dev.dio_oe ? dev.dio_n : 8'hff)};

  ////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic atn, input logic [7:0] b);
    @(posedge mclk);
    atn_n <= ~atn;
    dio_n <= ~b;
    repeat (3 + slow) @(posedge mclk);
    for (w = 0; w < 200 && !pins.nrfd_n; w++) @(posedge mclk);
    dav_n <= 1'b0;
    @(posedge mclk);
    for (w = 0; w < 200 && !pins.ndac_n; w++) @(posedge mclk);
    dav_n <= 1'b1;
    dio_n <= 8'hff;
    repeat (8) @(posedge mclk);
  endtask

  task automatic poll(input logic [7:0] mta, output logic [7:0] b);
    send(1'b1, {1'b0, CMD_SPE});
    send(1'b1, mta);
    @(posedge mclk);
    atn_n  <= 1'b1;
    ndac_n <= 1'b0;
    for (w = 0; w < 200 && pins.dav_n; w++) @(posedge mclk);
    b = ~pins.dio_n;
    repeat (slow) @(posedge mclk);
    ndac_n <= 1'b1;
    for (w = 0; w < 200 && !pins.dav_n; w++) @(posedge mclk);
    send(1'b1, {1'b0, CMD_SPD});
  endtask

  task automatic set_ren(input logic on);
    @(posedge mclk);
    ren_n <= ~on;
    repeat (4) @(posedge mclk);
  endtask

  task automatic ifc();
    @(posedge mclk);
    ifc_n <= 1'b0;
    repeat (IFC_CYC) @(posedge mclk);
    ifc_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
endmodule // irl_ctl_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import irl_pkg::*;

  localparam logic [6:0] MLA   = 7'h30;
  localparam logic [6:0] MTA   = 7'h50;
  localparam int         LIMIT = 20000;
  logic         mclk, resetn, avs_read, avs_write, key_local, rx_valid;
  logic         avs_waitrequest, dev_clear, bus_trigger, pre_trigger;
  logic [4:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, q;
  logic [7:0]   key_in, key_out, pb, rx_data, rx_last;
  irl_pin_in_t  pins_in;
  irl_pin_out_t pins_out;
  irl_lamps_t   lamps;
  int           error_cnt, total_checks, cyc, dcl_cnt, trg_cnt, pre_cnt;

  irl_bus_ctrl u_irl_bus_ctrl (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pins_in(pins_in), .pins_out(pins_out), .key_local(key_local),
    .key_in(key_in), .key_out(key_out), .lamps(lamps),
    .display_restore(), .dev_clear(dev_clear),
    .bus_trigger(bus_trigger), .pre_trigger(pre_trigger),
    .rx_data(rx_data), .rx_valid(rx_valid)
  );
  irl_ctl_model u_irl_ctl_model (.dev(pins_out), .mclk(mclk),
    .pins(pins_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask

  task automatic cmd(input logic [6:0] c);
    u_irl_ctl_model.send(1'b1, {1'b0, c});
  endtask

  task automatic press_local();
    @(posedge mclk);
    key_local <= 1'b1;
    repeat (6) @(posedge mclk);
    key_local <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (dev_clear === 1'b1) dcl_cnt++;
    if (bus_trigger === 1'b1) trg_cnt++;
    if (pre_trigger === 1'b1) pre_cnt++;
    if (rx_valid === 1'b1) rx_last = rx_data;
    if (cyc == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; key_local = 1'b0;
    avs_address = 5'h00; avs_writedata = 32'h0; key_in = 8'h5a;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(OFF_CTRL, 32'h10);
    bus(1'b1, 5'h14, 32'hff);
    rd(5'h14, 32'h0);
    u_irl_ctl_model.set_ren(1'b1);
    check(32'(lamps), 32'h0);
    cmd(MLA);
    check(32'(lamps), 32'ha);
    check(32'(key_out), 32'h0);
    press_local();
    check(32'(lamps), 32'h2);
    check(32'(key_out), 32'h5a);
    cmd(MLA);
    cmd(CMD_GTL);
    check(32'(lamps), 32'h2);
    check(32'(key_out), 32'h5a);
    cmd(MLA);
    cmd(CMD_LLO);
    press_local();
    check(32'(lamps), 32'ha);
    check(32'(key_out), 32'h0);
    rd(OFF_STATUS, 32'h4b);
    u_irl_ctl_model.set_ren(1'b0);
    rd(OFF_STATUS, 32'h08);
    cmd(MTA);
    check(32'(lamps), 32'h4);
    cmd(MLA);
    check(32'(lamps), 32'h2);
    cmd(CMD_UNL);
    check(32'(lamps), 32'h0);
    cmd(MTA);
    cmd(CMD_UNT);
    check(32'(lamps), 32'h0);
    cmd(CMD_SDC);
    check(32'(dcl_cnt), 32'h0);
    cmd(CMD_DCL);
    check(32'(dcl_cnt), 32'h1);
    cmd(MLA);
    cmd(CMD_SDC);
    check(32'(dcl_cnt), 32'h2);
    u_irl_ctl_model.send(1'b0, 8'ha5);
    check(32'(rx_last), 32'ha5);
    rd(OFF_CTRL, 32'h10);
    cmd(CMD_GET);
    check(32'(trg_cnt), 32'h0);
    bus(1'b1, OFF_CTRL, 32'h310);
    cmd(CMD_GET);
    check(32'(trg_cnt), 32'h1);
    check(32'(pre_cnt), 32'h1);
    bus(1'b1, OFF_SRE, 32'h1);
    bus(1'b1, OFF_STB, 32'h1);
    repeat (3) @(posedge mclk);
    check(32'(lamps), 32'h3);
    u_irl_ctl_model.poll({1'b0, MTA}, pb);
    check(32'(pb), 32'h41);
    check(32'(lamps), 32'h4);
    // Slow acceptor: the source must wait, not time out
    u_irl_ctl_model.slow = 5;
    u_irl_ctl_model.poll({1'b0, MTA}, pb);
    check(32'(pb), 32'h01);
    u_irl_ctl_model.set_ren(1'b1);
    cmd(MLA);
    check(32'(lamps), 32'ha);
    u_irl_ctl_model.ifc();
    check(32'(lamps), 32'h0);
    rd(OFF_CTRL, 32'h310);
    rd(OFF_SRE, 32'h1);
    rd(OFF_EVENT, 32'h7);
    bus(1'b1, OFF_EVENT, 32'h7);
    rd(OFF_EVENT, 32'h0);
    complete_run();
  end
endmodule // testbench
